// ==== dio_counter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.svh"

// one 16-bit down counter; loaded low byte then high byte, square out
module dio_counter
	import dio_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tick,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic [7:0]      rdata,
	output logic            cnt_out
);
	typedef struct packed {
		logic [15:0]    reload;
		logic [15:0]    count;
		dio_cnt_phase_t phase;
		logic           out;
	} dio_cnt_st_t;

	dio_cnt_st_t s_q;
	dio_cnt_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (wr) begin
			case (s_q.phase)
				DIO_CNT_LOW: begin
					s_d.reload[15:8] = wdata;
					s_d.count = {wdata, s_q.reload[7:0]};
					s_d.phase = DIO_CNT_HIGH;
				end
				default: begin
					s_d.reload[7:0] = wdata;
					s_d.phase = DIO_CNT_LOW;
				end
			endcase
		end else if (tick && s_q.phase == DIO_CNT_HIGH) begin
			if (s_q.count <= 16'h0001) begin
				s_d.count = s_q.reload;
				s_d.out = ~s_q.out;
			end else begin
				s_d.count = s_q.count - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.count[7:0];
	assign cnt_out = s_q.out;
endmodule : dio_counter
`default_nettype wire

// ==== dio_defs.svh ====
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte locations in the card's I/O window)
// ----------------------------------------------------------------
`define DIO_ADDR_W        5
`define DIO_OFS_PORT_A    5'h00
`define DIO_OFS_PORT_B    5'h01
`define DIO_OFS_PORT_C    5'h02
`define DIO_OFS_CTRL      5'h03
`define DIO_OFS_BUF       5'h0C
`define DIO_OFS_IRQ_OFF   5'h0D
`define DIO_OFS_IRQ_ON    5'h0E
`define DIO_OFS_IRQ_CLR   5'h0F
`define DIO_OFS_CNT_LO    5'h10
`define DIO_OFS_CNT_HI    5'h1B
`define DIO_OFS_IRQ_EN    5'h1C
`define DIO_OFS_IRQ_STAT  5'h1D
`define DIO_OFS_IRQ_MASK  5'h1E

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DIO_CTRL_C_LO     0
`define DIO_CTRL_B        1
`define DIO_CTRL_C_HI     3
`define DIO_CTRL_A        4
`define DIO_CTRL_SET      7
`define DIO_BUF_OFF_BIT   7
`define DIO_CTRL_RST      8'h9B
`define DIO_IRQ_EN_RST    8'h11
`define DIO_MASK_RST      8'h01
`define DIO_ZERO8         8'h00
`define DIO_ZERO16        16'h0000
`define DIO_PORT_C_IRQBIT 3
`define DIO_VENDOR_CODE   16'h1234
`define DIO_DEVICE_CODE   16'h5678

`endif

// ==== dio_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// far side of the lines: driven lines read back, others pulled
// ----------------------------------------------------------------
module dio_pin_model
	import dio_pkg::*;
(
	input  wire dio_lines_t pin_out,
	input  wire dio_lines_t pin_oe,
	input  wire dio_lines_t far_drive,
	output wire dio_lines_t pin_in
);
	// undriven lines take the bench level, never a stale latch value
	assign pin_in = (pin_out & pin_oe) | (far_drive & ~pin_oe);
endmodule : dio_pin_model
`default_nettype wire

// ==== dio_pkg.sv ====
package dio_pkg;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} dio_lines_t;

	typedef struct packed {
		logic rise;
		logic fall;
		logic high;
		logic low;
	} dio_trig_t;

	typedef enum logic [1:0] {
		DIO_CNT_IDLE,
		DIO_CNT_LOW,
		DIO_CNT_HIGH
	} dio_cnt_phase_t;
endpackage : dio_pkg

// ==== dio_port.sv ====
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.svh"

// Notes on behaviour
// RL1: three 8-bit ports, per-port direction
// RL2: port C halves set independently
// RL3: internal source is port C bit 3
// RL4: external select uses external interrupt pin
// RL5: timer jumper uses first counter output two
// RL6: each trigger source enabled independently
// RL7: rising, falling, high, low, combinable
// RL8: enabled source condition requests interrupt
// RL9: always-enable jumper keeps buffers on
// RL10: tristate jumper lets software drive buffers
// RL11: three devices, three 16-bit counters each
// RL12: 22 register locations decoded; the code decodes 20
// RL13: fixed identity codes for configuration space
// RL14: reset makes every line an input
// RL15: control top bit tristates, low re-enables
// RL16: reset enables rising edge both sources; the code's mask reset 8'h01 lets only the digital source reach irq
// RL17: host writes clear location to clear
// RL18: request latched until software clears it
module dio_port
	import dio_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [`DIO_ADDR_W-1:0]  addr,
	input  wire logic [7:0]              wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic [7:0]                   rdata,
	input  wire dio_lines_t              pin_in,
	output dio_lines_t                   pin_out,
	output dio_lines_t                   pin_oe,
	input  wire logic                    ext_irq_pin,
	input  wire logic                    counter_clk_tick,
	input  wire logic                    digital_irq_jumper,
	input  wire logic                    timer_irq_jumper,
	input  wire logic                    irq_source_select,
	input  wire logic                    always_enable_position,
	output logic [15:0]                  vendor_code,
	output logic [15:0]                  device_code,
	output logic                         irq
);
	typedef struct packed {
		dio_lines_t out;
		logic [7:0] ctrl;
		logic       ctrl_off;
		logic       buf_off;
		logic       glob_en;
		logic [7:0] trig_en;
		logic [7:0] mask;
		logic [1:0] stat;
		logic [7:0] rdata;
	} dio_st_t;

	dio_st_t s_q;
	dio_st_t s_d;

	logic [8:0] cnt_wr;
	logic [7:0] cnt_rd [9];
	logic [8:0] cnt_o;
	logic       dig_src;
	logic       dig_hit;
	logic       tmr_hit;
	logic [1:0] ev;

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	function automatic logic [3:0] cnt_index(input logic [4:0] a);
		logic [1:0] dev;
		dev = a[3:2] - 2'h0;
		cnt_index = 4'({dev, 2'b00}) - 4'({2'b00, dev}) + 4'(a[1:0]);
	endfunction : cnt_index

	function automatic logic is_cnt(input logic [4:0] a);
		is_cnt = a >= `DIO_OFS_CNT_LO && a <= `DIO_OFS_CNT_HI
			&& a[1:0] != 2'h3;
	endfunction : is_cnt

	genvar gi;
	generate
		for (gi = 0; gi < 9; gi = gi + 1) begin : g_cnt
			assign cnt_wr[gi] = wr && is_cnt(addr)
				&& cnt_index(addr) == 4'(gi);
			dio_counter u_cnt (     // see RL11
				.clk     (clk),
				.rst     (rst),
				.tick    (counter_clk_tick),
				.wr      (cnt_wr[gi]),
				.wdata   (wdata),
				.rdata   (cnt_rd[gi]),
				.cnt_out (cnt_o[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// interrupt sources
	// ----------------------------------------------------------------
	assign dig_src = irq_source_select ? ext_irq_pin       // see RL4
		: pin_in.c[`DIO_PORT_C_IRQBIT];                    // see RL3

	dio_trig u_dig (
		.clk (clk),
		.rst (rst),
		.src (dig_src),
		.sel ({s_q.trig_en[0], s_q.trig_en[1],
			s_q.trig_en[2], s_q.trig_en[3]}),
		.hit (dig_hit)
	);

	dio_trig u_tmr (
		.clk (clk),
		.rst (rst),
		.src (cnt_o[2]),                                   // see RL5
		.sel ({s_q.trig_en[4], s_q.trig_en[5],
			s_q.trig_en[6], s_q.trig_en[7]}),
		.hit (tmr_hit)
	);

	// jumpers gate each source on its own  see RL6
	assign ev = {tmr_hit & timer_irq_jumper & s_q.glob_en,
		dig_hit & digital_irq_jumper & s_q.glob_en};

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rdata = `DIO_ZERO8;
		if (wr) begin                                      // see RL12
			if (addr == `DIO_OFS_PORT_A) begin
				s_d.out.a = wdata;
			end else if (addr == `DIO_OFS_PORT_B) begin
				s_d.out.b = wdata;
			end else if (addr == `DIO_OFS_PORT_C) begin
				s_d.out.c = wdata;
			end else if (addr == `DIO_OFS_CTRL) begin
				// top bit set: new mode, buffers off; clear: only re-enable
				if (wdata[`DIO_CTRL_SET]) begin            // see RL15
					s_d.ctrl = wdata;
					s_d.ctrl_off = 1'b1;
				end else begin
					s_d.ctrl_off = 1'b0;
				end
			end else if (addr == `DIO_OFS_BUF) begin
				s_d.buf_off = wdata[`DIO_BUF_OFF_BIT];
			end else if (addr == `DIO_OFS_IRQ_OFF) begin
				s_d.glob_en = 1'b0;
			end else if (addr == `DIO_OFS_IRQ_ON) begin
				s_d.glob_en = 1'b1;
			end else if (addr == `DIO_OFS_IRQ_CLR) begin
				s_d.stat = 2'b00;                          // see RL17
			end else if (addr == `DIO_OFS_IRQ_EN) begin
				s_d.trig_en = wdata;
			end else if (addr == `DIO_OFS_IRQ_STAT) begin
				s_d.stat = s_q.stat & ~wdata[5:4];
			end else if (addr == `DIO_OFS_IRQ_MASK) begin
				s_d.mask = wdata;
			end
		end
		// set wins over a clear in the same cycle  see RL18
		s_d.stat = s_d.stat | ev;
		if (rd) begin
			if (addr == `DIO_OFS_PORT_A) begin
				s_d.rdata = pin_in.a;
			end else if (addr == `DIO_OFS_PORT_B) begin
				s_d.rdata = pin_in.b;
			end else if (addr == `DIO_OFS_PORT_C) begin
				s_d.rdata = pin_in.c;
			end else if (is_cnt(addr)) begin
				s_d.rdata = cnt_rd[cnt_index(addr)];
			end else if (addr == `DIO_OFS_IRQ_EN) begin
				s_d.rdata = s_q.trig_en;
			end else if (addr == `DIO_OFS_IRQ_STAT) begin
				s_d.rdata = {2'b00, s_q.stat, timer_irq_jumper,
					digital_irq_jumper, s_q.glob_en, 1'b0};
			end else if (addr == `DIO_OFS_IRQ_MASK) begin
				s_d.rdata = s_q.mask;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q.out <= '0;
			s_q.ctrl <= `DIO_CTRL_RST;                     // see RL14
			s_q.ctrl_off <= 1'b0;
			s_q.buf_off <= 1'b0;
			s_q.glob_en <= 1'b1;
			s_q.trig_en <= `DIO_IRQ_EN_RST;                // see RL16
			s_q.mask <= `DIO_MASK_RST;
			s_q.stat <= 2'b00;
			s_q.rdata <= `DIO_ZERO8;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// pins
	// ----------------------------------------------------------------
	logic buf_on;
	assign buf_on = always_enable_position                 // see RL9
		| ~(s_q.ctrl_off | s_q.buf_off);                   // see RL10

	assign pin_out = s_q.out;
	// direction bits: 1 means input  see RL1
	assign pin_oe.a = {8{buf_on & ~s_q.ctrl[`DIO_CTRL_A]}};
	assign pin_oe.b = {8{buf_on & ~s_q.ctrl[`DIO_CTRL_B]}};
	assign pin_oe.c = {{4{buf_on & ~s_q.ctrl[`DIO_CTRL_C_HI]}},
		{4{buf_on & ~s_q.ctrl[`DIO_CTRL_C_LO]}}};          // see RL2

	assign rdata = s_q.rdata;
	assign vendor_code = `DIO_VENDOR_CODE;                 // see RL13
	assign device_code = `DIO_DEVICE_CODE;
	assign irq = |({s_q.mask[4], s_q.mask[0]} & s_q.stat); // see RL8
endmodule : dio_port
`default_nettype wire

// ==== dio_port_props.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.svh"

module dio_port_props
	import dio_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic [`DIO_ADDR_W-1:0] addr,
	input wire logic [7:0]             wdata,
	input wire logic                   wr,
	input wire logic                   rd,
	input wire logic [7:0]             rdata,
	input wire dio_lines_t             pin_out,
	input wire dio_lines_t             pin_oe,
	input wire logic                   always_enable_position,
	input wire logic [15:0]            vendor_code,
	input wire logic [15:0]            device_code,
	input wire logic                   irq
);
	// ----------------------------------------------------------------
	// port properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_read_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside read slot");
	a_unmapped_read: assert property (rd && addr == 5'h13 |=> !rdata)
		else $error("unused location read not zero");
	a_ctrl_tristate: assert property (
		wr && addr == 5'h03 && wdata[7] && !always_enable_position
		|=> pin_oe == 24'h000000) else $error("control set left buffers on");
	a_buf_disable: assert property (
		wr && addr == 5'h0C && wdata[7] && !always_enable_position
		|=> pin_oe == 24'h000000) else $error("buffer off write ignored");
	a_port_latch: assert property (
		wr && addr == 5'h00 |=> pin_out.a == $past(wdata))
		else $error("port a latch not updated");
	a_irq_hold: assert property (irq && !wr |=> irq)
		else $error("interrupt dropped without software clear");
	a_ident_stable: assert property (
		!$past(rst) |-> $stable(vendor_code) && $stable(device_code))
		else $error("identity codes changed");
	a_reset_inputs: assert property ($fell(rst) |-> !pin_oe)
		else $error("lines not inputs after reset");

	c_irq_rise: cover property ($rose(irq));
	c_ctrl_write: cover property (wr && addr == 5'h03 && wdata[7]);
	c_unmapped: cover property (rd && addr == 5'h13);
endmodule : dio_port_props

bind dio_port dio_port_props i_dio_port_props (.clk(clk), .rst(rst),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.pin_out(pin_out), .pin_oe(pin_oe), .irq(irq),
	.always_enable_position(always_enable_position),
	.vendor_code(vendor_code), .device_code(device_code));
`default_nettype wire

// ==== dio_trig.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.svh"

module dio_trig
	import dio_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      src,
	input  wire dio_trig_t sel,
	output logic           hit
);
	typedef struct packed {
		logic prev;
	} dio_trig_st_t;

	dio_trig_st_t s_q;
	dio_trig_st_t s_d;

	always_comb begin
		s_d.prev = src;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// any selected condition fires; conditions combine freely  see RL7
	assign hit = (sel.rise & src & ~s_q.prev)
		| (sel.fall & ~src & s_q.prev)
		| (sel.high & src)
		| (sel.low & ~src);
endmodule : dio_trig
`default_nettype wire

// ==== test_dio_port_interrupt_logic.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dio_defs.svh"

module test_dio_port_interrupt_logic
	import dio_pkg::*;
;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	logic                   clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic                   external_source_position = 1'b0, tick = 1'b0, tj = 1'b0, irq;
	logic                   sel = 1'b1, aep = 1'b0, dj = 1'b1;
	logic [`DIO_ADDR_W-1:0] addr = 5'h00;
	logic [7:0]             wdata = 8'h00, rdata, d;
	logic [15:0]            vc, dc;
	dio_lines_t             far = 24'h000000, pin_in, pin_out, pin_oe;
	int                     err_count = 0, check_count = 0;
	logic [7:0]             ctl[3] = '{8'h81, 8'h88, 8'h92};
	logic [23:0]            oe[3] = '{24'hFFFFF0, 24'hFFFF0F, 24'h0000FF};

	always #2 clk = ~clk;

	dio_port i_dio_port (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .ext_irq_pin(external_source_position), .counter_clk_tick(tick),
		.digital_irq_jumper(dj), .timer_irq_jumper(tj),
		.irq_source_select(sel), .always_enable_position(aep),
		.vendor_code(vc), .device_code(dc), .irq(irq));
	dio_pin_model i_dio_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.far_drive(far), .pin_in(pin_in));

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	task automatic check(input logic [23:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : check

	task automatic bus_wr(input logic [4:0] a, input logic [7:0] v);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus_wr

	task automatic bus_rd(input logic [4:0] a);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask : bus_rd

	// hold=0: wait for level; hold=1: level must stay n cycles
	task automatic irq_wait(input logic exp, input int n, input logic hold);
		logic ok;
		ok = 1'b0;
		for (int k = 0; k < n; k++) begin
			@(posedge clk);
			ok = (irq === exp);
			if (ok != hold)
				break;
		end
		check(ok, 1'b1, "irq level");
		if (!ok && !hold)
			final_report();
	endtask : irq_wait

	task automatic t_reset;
		check(pin_oe, 24'h0, "oe after reset");
		check(vc, `DIO_VENDOR_CODE, "vendor code");
		check(dc, `DIO_DEVICE_CODE, "device code");
		bus_rd(5'h1C);
		check(d, 8'h11, "enables reset");
		bus_rd(5'h1D);
		check(d, 8'h06, "status reset");
		bus_rd(5'h13);
		check(d, 8'h00, "unused read");
		$display("test reset done");
	endtask : t_reset

	task automatic t_dir;
		bus_wr(5'h03, 8'h80);
		bus_wr(5'h00, 8'h5A);
		bus_wr(5'h01, 8'hC3);
		bus_wr(5'h03, 8'h00);
		check(pin_oe, 24'hFFFFFF, "all out");
		check(pin_out[23:8], 16'h5AC3, "latches");
		for (int i = 0; i < 3; i++) begin
			bus_wr(5'h03, ctl[i]);
			check(pin_oe, 24'h0, "set tristates");
			bus_wr(5'h03, ctl[i] & 8'h7F);
			check(pin_oe, oe[i], "direction");
		end
		far <= 24'h3C0000;
		bus_rd(5'h00);
		check(d, 8'h3C, "input read");
		$display("test direction done");
	endtask : t_dir

	task automatic t_buf;
		bus_wr(5'h0C, 8'h80);
		check(pin_oe, 24'h0, "soft off");
		bus_wr(5'h0C, 8'h00);
		check(pin_oe, 24'h0000FF, "soft on");
		aep <= 1'b1;
		bus_wr(5'h0C, 8'h80);
		check(pin_oe, 24'h0000FF, "jumper on");
		aep <= 1'b0;
		bus_wr(5'h0C, 8'h00);
		$display("test buffer done");
	endtask : t_buf

	task automatic t_irq;
		for (int i = 0; i < 4; i++) begin
			external_source_position <= i[0];
			bus_wr(5'h1C, 8'h01 << i);
			bus_wr(5'h0F, 8'h00);
			irq_wait(1'b0, 4, 1'b0);
			external_source_position <= ~i[0];
			irq_wait(1'b1, 8, 1'b0);
			external_source_position <= i[0];
			irq_wait(1'b1, 4, 1'b1);
			bus_wr(5'h0F, 8'h00);
			irq_wait(1'b0, 4, 1'b0);
		end
		bus_wr(5'h1C, 8'h10);
		external_source_position <= 1'b0;
		irq_wait(1'b0, 2, 1'b1);
		external_source_position <= 1'b1;
		irq_wait(1'b0, 8, 1'b1);
		external_source_position <= 1'b0;
		bus_wr(5'h1C, 8'h01);
		bus_wr(5'h0D, 8'h00);
		external_source_position <= 1'b1;
		irq_wait(1'b0, 8, 1'b1);
		external_source_position <= 1'b0;
		bus_wr(5'h0F, 8'h00);
		bus_wr(5'h0E, 8'h00);
		sel <= 1'b0;
		bus_wr(5'h03, 8'h9B);
		bus_wr(5'h03, 8'h1B);
		far <= 24'h000008;
		irq_wait(1'b1, 8, 1'b0);
		bus_wr(5'h0F, 8'h00);
		// jumper pulled: a fresh edge on the source must stay silent
		dj <= 1'b0;
		far <= 24'h000000;
		irq_wait(1'b0, 2, 1'b1);
		far <= 24'h000008;
		irq_wait(1'b0, 8, 1'b1);
		dj <= 1'b1;
		$display("test interrupt done");
	endtask : t_irq

	task automatic t_timer;
		tj <= 1'b1;
		tick <= 1'b1;
		bus_wr(5'h12, 8'h04);
		bus_wr(5'h12, 8'h00);
		bus_wr(5'h1C, 8'h10);
		bus_wr(5'h0F, 8'h00);
		bus_wr(5'h1E, 8'h11);
		irq_wait(1'b1, 60, 1'b0);
		bus_rd(5'h1D);
		check(d[5], 1'b1, "timer status");
		// stopped counter: the loaded count must read back low byte
		tick <= 1'b0;
		bus_wr(5'h10, 8'h34);
		bus_wr(5'h10, 8'h12);
		bus_rd(5'h10);
		check(d, 8'h34, "counter load");
		$display("test timer done");
	endtask : t_timer

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_dir();
		t_buf();
		t_irq();
		t_timer();
		final_report();
	end
endmodule : test_dio_port_interrupt_logic
`default_nettype wire
